/* hw/sic_pkg.sv */
// shared constants, types and detection helper for the interrupt controller
package sic_pkg;

  localparam int SRC_CNT = 24;
  localparam int DST_CNT = 4;
  localparam int EXT_CNT = 2;
  localparam int PORT_CNT_DEF = 4;

  // fixed source bit positions
  localparam int SRC_AGG = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_INT_LO = 3;
  localparam int INT_CNT = SRC_CNT - SRC_INT_LO;

  // fixed destination replication indices
  localparam int DST_PROCESSOR_IRQ_ZERO = 0;
  localparam int DST_PROCESSOR_IRQ_ONE = 1;
  localparam int DST_EXT0 = 2;
  localparam int DST_EXT1 = 3;

  // values after reset
  localparam logic [SRC_CNT-1:0] SRC_RST = 24'h000000;
  localparam logic [EXT_CNT-1:0] EXT_RST = 2'h0;
  localparam logic BIT_RST = 1'b0;

  typedef enum logic [1:0] {
    SIC_DET_LEVEL = 2'b00,
    SIC_DET_ANY = 2'b01,
    SIC_DET_FALL = 2'b10,
    SIC_DET_RISE = 2'b11
  } sic_det_t;

  typedef struct packed {
    logic [SRC_CNT-1:0][1:0] detect_method_select;
    logic [SRC_CNT-1:0] source_enable_mask;
    logic [SRC_CNT-1:0] latch_bypass_select;
  } sic_src_cfg_t;

  typedef struct packed {
    logic [EXT_CNT-1:0] ext_input_polarity;
    logic [EXT_CNT-1:0] ext_output_polarity;
    logic [EXT_CNT-1:0] ext_output_drive_style;
  } sic_ext_cfg_t;

  // event condition for one source from current and previous level
  function automatic logic sic_detect(input logic [1:0] method,
                                      input logic cur,
                                      input logic prev);
    logic hit;
    hit = 1'b0;
    unique case (sic_det_t'(method))
      SIC_DET_LEVEL: hit = cur;
      SIC_DET_ANY: hit = cur ^ prev;
      SIC_DET_FALL: hit = prev & ~cur;
      SIC_DET_RISE: hit = cur & ~prev;
    endcase
    return hit;
  endfunction

endpackage

/* hw/sic_switch_irq.sv */
// interrupt controller: source, port-level and destination logic
`timescale 1ns/1ps
`default_nettype none
// How it works
// - raw source levels readable per bit
// - level mode sets latch while active
// - edge mode sets latch on any change
// - falling mode sets latch on active-to-inactive
// - rising mode sets latch on inactive-to-active
// - writing one clears latch; zero ignored
// - clear never hides a live event
// - latched and enabled source goes to targets
// - active and enabled sources shown in view
// - bypass uses raw level, skips latch
// - each target masks sources on its own
// - each target shows its pending sources
// - port interrupts aggregate into source zero
// - per-port polarity applied before detection
// - port hierarchy mirrors top-level source logic
// - two external inputs, two outputs, independent
// - per-line polarity for external inputs, outputs
// - drive style zero drives both levels
// - drive style one, polarity zero: open collector
// - source bit positions are fixed
// - target indices are fixed
// - active high inside, polarity at edges
module sic_switch_irq
  import sic_pkg::*;
#(
  parameter int PORT_CNT = PORT_CNT_DEF
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [INT_CNT-1:0] internal_sources,
  input wire logic ext_input_line_zero,
  input wire logic ext_input_line_one,
  input wire logic [PORT_CNT-1:0] port_irq,
  input wire sic_src_cfg_t src_cfg,
  input wire logic [SRC_CNT-1:0] latched_event_clear,
  input wire logic [DST_CNT-1:0][SRC_CNT-1:0] target_source_mask,
  input wire logic [PORT_CNT-1:0] port_irq_polarity,
  input wire logic [PORT_CNT-1:0][1:0] port_detect_method,
  input wire logic [PORT_CNT-1:0] port_enable_mask,
  input wire logic [PORT_CNT-1:0] port_latch_bypass,
  input wire logic [PORT_CNT-1:0] port_latched_clear,
  input wire sic_ext_cfg_t ext_cfg,
  output logic [SRC_CNT-1:0] source_level_view,
  output logic [SRC_CNT-1:0] latched_event_bits,
  output logic [SRC_CNT-1:0] active_enabled_view,
  output logic [DST_CNT-1:0][SRC_CNT-1:0] target_pending_view,
  output logic [PORT_CNT-1:0] port_level_view,
  output logic [PORT_CNT-1:0] port_latched_events,
  output logic [PORT_CNT-1:0] port_active_view,
  output logic aggregated_port_source,
  output logic processor_irq_zero,
  output logic processor_irq_one,
  output logic ext_output_line_zero,
  output logic ext_output_line_zero_oe,
  output logic ext_output_line_one,
  output logic ext_output_line_one_oe
);

  // port-level hierarchy
  logic [PORT_CNT-1:0] port_prev;
  logic [PORT_CNT-1:0] next_port_level;
  logic [PORT_CNT-1:0] next_port_latched;
  logic [PORT_CNT-1:0] next_port_active;
  logic next_port_agg;

  always_comb
  begin
    next_port_level = port_irq ~^ port_irq_polarity;
    next_port_latched = port_latched_events;
    next_port_active = '0;
    for (int m = 0; m < PORT_CNT; m++)
    begin
      // set after clear so a same-cycle event survives
      if (port_latched_clear[m])
      begin
        next_port_latched[m] = 1'b0;
      end
      if (sic_detect(port_detect_method[m], port_level_view[m],
                     port_prev[m]))
      begin
        next_port_latched[m] = 1'b1;
      end
      if (port_latch_bypass[m])
      begin
        next_port_active[m] = port_level_view[m] & port_enable_mask[m];
      end
      else
      begin
        next_port_active[m] = port_latched_events[m] & port_enable_mask[m];
      end
    end
    next_port_agg = |port_active_view;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      port_level_view <= '0;
      port_prev <= '0;
      port_latched_events <= '0;
      port_active_view <= '0;
      aggregated_port_source <= BIT_RST;
    end
    else
    begin
      port_level_view <= next_port_level;
      port_prev <= port_level_view;
      port_latched_events <= next_port_latched;
      port_active_view <= next_port_active;
      aggregated_port_source <= next_port_agg;
    end
  end

  // top-level sources
  logic [SRC_CNT-1:0] src_prev;
  logic [SRC_CNT-1:0] next_level;
  logic [SRC_CNT-1:0] next_latched;
  logic [SRC_CNT-1:0] indicated;
  logic [SRC_CNT-1:0] next_active;

  always_comb
  begin
    // polarity corrected before entry, active high inside
    next_level = SRC_RST;
    next_level[SRC_AGG] = aggregated_port_source;
    next_level[SRC_EXT0] = ext_input_line_zero
                           ~^ ext_cfg.ext_input_polarity[0];
    next_level[SRC_EXT1] = ext_input_line_one
                           ~^ ext_cfg.ext_input_polarity[1];
    next_level[SRC_CNT-1:SRC_INT_LO] = internal_sources;
    next_latched = latched_event_bits;
    for (int n = 0; n < SRC_CNT; n++)
    begin
      if (latched_event_clear[n])
      begin
        next_latched[n] = 1'b0;
      end
      // level, any edge, falling or rising per method
      if (sic_detect(src_cfg.detect_method_select[n],
                     source_level_view[n], src_prev[n]))
      begin
        next_latched[n] = 1'b1;
      end
    end
    // bypass takes the raw level; only safe for sticky sources
    indicated = SRC_RST;
    for (int n = 0; n < SRC_CNT; n++)
    begin
      if (src_cfg.latch_bypass_select[n])
      begin
        indicated[n] = source_level_view[n];
      end
      else
      begin
        indicated[n] = latched_event_bits[n];
      end
    end
    next_active = indicated & src_cfg.source_enable_mask;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      source_level_view <= SRC_RST;
      src_prev <= SRC_RST;
      latched_event_bits <= SRC_RST;
      active_enabled_view <= SRC_RST;
    end
    else
    begin
      source_level_view <= next_level;
      src_prev <= source_level_view;
      latched_event_bits <= next_latched;
      active_enabled_view <= next_active;
    end
  end

  // destinations
  logic [DST_CNT-1:0][SRC_CNT-1:0] next_pending;
  logic [DST_CNT-1:0] dst_hit;
  logic [EXT_CNT-1:0] next_ext_out;
  logic [EXT_CNT-1:0] next_ext_oe;

  always_comb
  begin
    for (int d = 0; d < DST_CNT; d++)
    begin
      next_pending[d] = next_active & target_source_mask[d];
      dst_hit[d] = |next_pending[d];
    end
    for (int e = 0; e < EXT_CNT; e++)
    begin
      // polarity applied after leaving the controller
      if (ext_cfg.ext_output_drive_style[e])
      begin
        // drive the active level only while asserted, else release
        next_ext_out[e] = ext_cfg.ext_output_polarity[e];
        next_ext_oe[e] = dst_hit[DST_EXT0+e];
      end
      else
      begin
        next_ext_out[e] = dst_hit[DST_EXT0+e]
                          ~^ ext_cfg.ext_output_polarity[e];
        next_ext_oe[e] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      target_pending_view <= '0;
      processor_irq_zero <= BIT_RST;
      processor_irq_one <= BIT_RST;
      ext_output_line_zero <= BIT_RST;
      ext_output_line_zero_oe <= BIT_RST;
      ext_output_line_one <= BIT_RST;
      ext_output_line_one_oe <= BIT_RST;
    end
    else
    begin
      target_pending_view <= next_pending;
      processor_irq_zero <= dst_hit[DST_PROCESSOR_IRQ_ZERO];
      processor_irq_one <= dst_hit[DST_PROCESSOR_IRQ_ONE];
      ext_output_line_zero <= next_ext_out[0];
      ext_output_line_zero_oe <= next_ext_oe[0];
      ext_output_line_one <= next_ext_out[1];
      ext_output_line_one_oe <= next_ext_oe[1];
    end
  end

endmodule
`default_nettype wire

/* test/sic_far_end.sv */
// far-side model of the two external interrupt wires
`timescale 1ns/1ps
`default_nettype none
module sic_far_end (
  input wire logic pin0,
  input wire logic oe0,
  input wire logic pin1,
  input wire logic oe1,
  output logic wire0,
  output logic wire1
);
  // a released wire is pulled high by the board resistor
  assign wire0 = oe0 ? pin0 : 1'b1;
  assign wire1 = oe1 ? pin1 : 1'b1;
endmodule
`default_nettype wire

/* test/sic_irq_sva.sv */
// assertion checker on the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module sic_irq_sva
  import sic_pkg::*;
#(
  parameter int PORT_CNT = PORT_CNT_DEF
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire sic_src_cfg_t src_cfg,
  input wire logic [SRC_CNT-1:0] latched_event_clear,
  input wire logic [DST_CNT-1:0][SRC_CNT-1:0] target_source_mask,
  input wire sic_ext_cfg_t ext_cfg,
  input wire logic [SRC_CNT-1:0] source_level_view,
  input wire logic [SRC_CNT-1:0] latched_event_bits,
  input wire logic [SRC_CNT-1:0] active_enabled_view,
  input wire logic [DST_CNT-1:0][SRC_CNT-1:0] target_pending_view,
  input wire logic [PORT_CNT-1:0] port_active_view,
  input wire logic aggregated_port_source,
  input wire logic processor_irq_zero,
  input wire logic ext_output_line_zero,
  input wire logic ext_output_line_zero_oe
);
  logic [SRC_CNT-1:0] byp, sel;
  logic [1:0] m;
  logic s, l, c, t, d, p;
  assign byp = src_cfg.latch_bypass_select;
  assign sel = (latched_event_bits & ~byp | source_level_view & byp)
    & src_cfg.source_enable_mask;
  assign m = src_cfg.detect_method_select[3];
  assign s = source_level_view[3];
  assign l = latched_event_bits[3];
  assign c = latched_event_clear[3];
  assign t = |target_pending_view[2];
  assign d = ext_cfg.ext_output_drive_style[0];
  assign p = ext_cfg.ext_output_polarity[0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  level_sets_a: assert property (m==2'h0 && s |=> l)
    else $error("level source not latched");
  rise_sets_a: assert property (m==2'h3 && $rose(s) |=> l)
    else $error("rising edge not latched");
  fall_only_a: assert property (
    m==2'h2 && !l && !$fell(s) |=> !l)
    else $error("latched without falling edge");
  clear_wins_a: assert property (c && |m && $stable(s) |=> !l)
    else $error("latched bit not cleared");
  act_view_a: assert property (
    active_enabled_view == $past(sel)) else $error("enabled view wrong");
  target_map_a: assert property (
    $stable(target_source_mask) |-> target_pending_view[1] ==
    (active_enabled_view & target_source_mask[1])
    && processor_irq_zero == |target_pending_view[0])
    else $error("target view or irq wrong");
  push_pull_a: assert property (
    !d && $past(rst_n, 2) && $stable(ext_cfg) |-> ext_output_line_zero_oe
    && ext_output_line_zero == (t ~^ p)) else $error("push-pull wrong");
  open_drain_a: assert property (
    d && !p && $stable(ext_cfg) |-> ext_output_line_zero_oe == t
    && !ext_output_line_zero) else $error("open collector wrong");
  port_agg_a: assert property (
    |port_active_view |=> aggregated_port_source ##1 source_level_view[0])
    else $error("port source not aggregated");
endmodule
bind sic_switch_irq sic_irq_sva #(.PORT_CNT(PORT_CNT)) i_sva (
  .clk(clk),
  .rst_n(rst_n),
  .src_cfg(src_cfg),
  .latched_event_clear(latched_event_clear),
  .target_source_mask(target_source_mask),
  .ext_cfg(ext_cfg),
  .source_level_view(source_level_view),
  .latched_event_bits(latched_event_bits),
  .active_enabled_view(active_enabled_view),
  .target_pending_view(target_pending_view),
  .port_active_view(port_active_view),
  .aggregated_port_source(aggregated_port_source),
  .processor_irq_zero(processor_irq_zero),
  .ext_output_line_zero(ext_output_line_zero),
  .ext_output_line_zero_oe(ext_output_line_zero_oe)
);
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the switch interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sic_pkg::*;
  logic clk, irq0, irq1, o0, oe0, o1, oe1, w0, w1, aggregated_port_source;
  logic rst_n = 1'b0;
  logic ei0 = 1'b0;
  logic ei1 = 1'b1;
  logic [INT_CNT-1:0] isrc = 21'h0;
  logic [3:0] pirq = 4'h1;
  logic [3:0] port_irq_polarity = 4'hE;
  logic [3:0] port_enable_mask = 4'hF;
  logic [3:0] port_latch_bypass = 4'h0;
  logic [3:0] port_latched_clear = 4'h0;
  logic [3:0][1:0] port_detect_method = 8'h0;
  logic [3:0] port_level_view, port_latched_events, port_active_view;
  logic [SRC_CNT-1:0] lvl, lat, act;
  logic [SRC_CNT-1:0] clr = 24'h0;
  logic [DST_CNT-1:0][SRC_CNT-1:0] target_pending_view;
  logic [DST_CNT-1:0][SRC_CNT-1:0] tm = {24'h0, 24'h2, 24'h4, 24'hFFFFFF};
  sic_src_cfg_t sc;
  sic_ext_cfg_t xc;
  int failures = 0;
  int tests_run = 0;
  sic_switch_irq i_dut (.internal_sources(isrc), .ext_input_line_zero(ei0),
    .ext_input_line_one(ei1), .port_irq(pirq), .src_cfg(sc), .ext_cfg(xc),
    .latched_event_clear(clr), .target_source_mask(tm),
    .source_level_view(lvl), .latched_event_bits(lat),
    .active_enabled_view(act), .processor_irq_zero(irq0),
    .processor_irq_one(irq1), .ext_output_line_zero(o0),
    .ext_output_line_zero_oe(oe0), .ext_output_line_one(o1),
    .ext_output_line_one_oe(oe1), .clk(clk), .rst_n(rst_n),
    .port_irq_polarity(port_irq_polarity),
    .port_detect_method(port_detect_method),
    .port_enable_mask(port_enable_mask),
    .port_latch_bypass(port_latch_bypass),
    .port_latched_clear(port_latched_clear),
    .target_pending_view(target_pending_view),
    .port_level_view(port_level_view),
    .port_latched_events(port_latched_events),
    .port_active_view(port_active_view),
    .aggregated_port_source(aggregated_port_source));
  sic_far_end i_far (.pin0(o0), .oe0(oe0), .pin1(o1), .oe1(oe1),
    .wire0(w0), .wire1(w1));
  task automatic chk(input string nm, input logic [23:0] got,
    input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle write-one-to-clear strobe
  task automatic wclr(input logic [23:0] b);
    clr = b;
    step(1);
    clr = 24'h0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (600) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial
  begin
    sc = 96'h0;
    sc.source_enable_mask = 24'hFFFFFF;
    sc.latch_bypass_select = 24'h10;
    xc = 6'h18;
    step(6);
    rst_n = 1'b1;
    step(2);
    ei0 = 1'b1;
    step(3);
    chk("lvl", lvl, 24'h2);
    chk("lat", lat, 24'h2);
    chk("irq", {22'h0, irq1, irq0}, 24'h1);
    chk("pend2", target_pending_view[2], 24'h2);
    chk("out0", {23'h0, w0}, 24'h0);
    wclr(24'h2);
    xc = 6'h19;
    step(1);
    chk("lat", lat, 24'h2);
    chk("out0", {23'h0, w0}, 24'h0);
    ei0 = 1'b0;
    step(2);
    wclr(24'h2);
    step(2);
    chk("lat", lat, 24'h0);
    chk("outs", {22'h0, w1, w0}, 24'h1);
    for (int m = 0; m < 4; m++)
    begin
      sc.detect_method_select[3] = 2'(m);
      isrc[0] = 1'b1;
      step(3);
      chk("rise", {23'h0, lat[3]}, {23'h0, m != 2});
      wclr(24'h8);
      isrc[0] = 1'b0;
      step(3);
      chk("fall", {23'h0, lat[3]}, {23'h0, m != 3});
      wclr(24'h8);
      step(1);
    end
    // source 4 is a pulse the bench drops again before software clears it
    isrc[1] = 1'b1;
    step(3);
    isrc[1] = 1'b0;
    step(3);
    chk("byp", {22'h0, act[4], lat[4]}, 24'h1);
    wclr(24'h10);
    ei1 = 1'b0;
    step(2);
    chk("lvl", lvl, 24'h4);
    pirq[0] = 1'b0;
    step(8);
    chk("port", {21'h0, aggregated_port_source, port_level_view[0],
      port_active_view[0]}, 24'h7);
    chk("dev", {22'h0, lat[0], lvl[0]}, 24'h3);
    chk("act", act, 24'h5);
    chk("pend1", target_pending_view[1], 24'h4);
    chk("irq", {22'h0, irq1, irq0}, 24'h3);
    pirq[0] = 1'b1;
    port_latch_bypass = 4'h1;
    step(2);
    chk("plat", {20'h0, port_latched_events}, 24'h1);
    chk("pact", {20'h0, port_active_view}, 24'h0);
    port_latched_clear = 4'h1;
    step(1);
    port_latched_clear = 4'h0;
    step(1);
    chk("pclr", {20'h0, port_latched_events}, 24'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
